// ### rtl/aol_alarm_lines.sv
// Purpose: Four alarm output lines fed by per-reading limit results
// Assumes: Limit comparison runs on core_clk_i and gives one reading per cycle at most
// Notes:   Zero-wait AHB-Lite slave; pins are registered, one cycle behind the state
//          Limit comparison stays outside; only its per-reading verdict comes in here
//          Bus answer signals come from flops so every output starts at a register
// Function
// - Four lines; clear deasserts one addressed line or all four.
// - Clear is accepted any time and keeps stored alarm records.
// - New scan deasserts all lines and erases alarm records.
// - Factory reset deasserts all lines, keeps the alarm record count.
// - Enable query reports routed channels with checking on, per line.
// - Each line latched or tracking; unindexed write sets all four.
// - Latched line goes active on first alarm until clear or scan.
// - Tracking line active while reading out of limits, drops automatically.
// - Factory reset sets every line to latched behaviour.
// - Polarity per line: active-low drives low, active-high drives high.
// - Unindexed polarity write sets all four lines at once.
// - Factory reset sets every line active-low.
// - Each channel routed to exactly one line; rerouting replaces it.
// - Line alarms when any reading of a routed channel with checking on violates limits.
// - Factory reset routes every channel to the first line.
// - Factory reset and rst_i disable checking; clears and new scan keep the enables.
// - Routing query returns every channel routed to a line.
// - Behaviour and polarity settings can be read back per line.
`timescale 1ns/1ps
`default_nettype none
module aol_alarm_lines
  import aol_pkg::*;
#(
  parameter int NUM_CH = 64
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      hsel_i,
  input  wire logic [31:0]               haddr_i,
  input  wire logic [1:0]                htrans_i,
  input  wire logic                      hwrite_i,
  input  wire logic [2:0]                hsize_i,
  input  wire logic [31:0]               hwdata_i,
  input  wire logic                      hready_i,
  output logic [31:0]                    hrdata_o,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  input  wire logic                      rd_valid_i,
  input  wire logic [$clog2(NUM_CH)-1:0] rd_chan_i,
  input  wire logic                      rd_out_i,
  output logic [NUM_LINES-1:0]           alarm_o
);
  localparam int CHW = $clog2(NUM_CH);
  localparam int GW  = CHW - GRP_SH;

  // Channel ranges are 8-bit fields and masks come in whole 32-channel groups
  if (NUM_CH < 2 * GRP_CH || NUM_CH > (1 << RANGE_W) || NUM_CH != (1 << CHW)) begin : g_chk
    $error("NUM_CH must be a power of two from 64 to 256");
  end

  // Bus and configuration state
  logic                 wr_pend_ff;
  logic [7:0]           wr_addr_ff;
  logic [31:0]          hrdata_ff;
  logic [NUM_LINES-1:0] mode_ff;
  logic [NUM_LINES-1:0] pol_ff;
  logic [1:0]           route_ff [NUM_CH];
  logic [NUM_CH-1:0]    en_ff;
  logic [NUM_CH-1:0]    out_ff;
  logic [NUM_LINES-1:0] latch_ff;
  logic [NUM_LINES-1:0] alarm_ff;
  logic [REC_W-1:0]     rec_ff;
  logic [1:0]           qline_ff;
  logic [GW-1:0]        qgrp_ff;

  // Range membership, used by routing and enable writes alike
  function automatic logic in_range(input int unsigned c, input logic [31:0] w);
    in_range = (c >= 32'(w[RANGE_LO_LSB +: RANGE_W])) && (c <= 32'(w[RANGE_HI_LSB +: RANGE_W]));
  endfunction

  // Address phase decode
  wire       addr_ok  = hsel_i & htrans_i[1] & hready_i;
  wire       mapped   = (haddr_i[31:MAP_TOP_LSB] == '0) && (haddr_i[1:0] == 2'h0);
  wire [7:0] a_off    = haddr_i[7:0];

  // Data phase write strobes; only whole words are honoured
  wire wr_cmd    = wr_pend_ff & (wr_addr_ff == ADDR_CMD);
  wire wr_cfg    = wr_pend_ff & (wr_addr_ff == ADDR_CFG);
  wire wr_route  = wr_pend_ff & (wr_addr_ff == ADDR_ROUTE);
  wire wr_enable = wr_pend_ff & (wr_addr_ff == ADDR_ENABLE);
  wire wr_qsel   = wr_pend_ff & (wr_addr_ff == ADDR_QSEL);

  // Command pulses
  wire       clr_one  = wr_cmd & hwdata_i[CMD_CLR_ONE_BIT];
  wire       clr_all  = wr_cmd & hwdata_i[CMD_CLR_ALL_BIT];
  wire       new_scan = wr_cmd & hwdata_i[CMD_NEW_SCAN_BIT];
  wire       frst     = wr_cmd & hwdata_i[CMD_FRST_BIT];
  wire [1:0] cmd_line = hwdata_i[CMD_LINE_LSB +: 2];

  // Lines to deassert this cycle; scan start counts as a clear of all
  wire [NUM_LINES-1:0] clr_mask = (clr_one ? (NUM_LINES'(1) << cmd_line) : '0)
                                | ((clr_all | new_scan) ? '1 : '0);

  // Reading qualified by the channel's own checking enable
  wire       rd_en   = rd_valid_i & en_ff[rd_chan_i];
  wire       ev      = rd_en & rd_out_i;
  wire [1:0] ev_ln   = route_ff[rd_chan_i];
  wire [NUM_LINES-1:0] ev_line = ev ? (NUM_LINES'(1) << ev_ln) : '0;

  // Tracking view: any routed channel whose last reading was out of limits
  logic [NUM_LINES-1:0] track_act;
  always_comb begin
    track_act = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      track_act[route_ff[c]] = track_act[route_ff[c]] | out_ff[c];
    end
  end

  // Line state in the selected behaviour, then mapped to the pin level
  wire [NUM_LINES-1:0] act     = (mode_ff & track_act) | (~mode_ff & latch_ff);
  wire [NUM_LINES-1:0] nxt_pin = ~(act ^ pol_ff);

  // Latch: set wins over clear so a coincident alarm is not lost
  wire [NUM_LINES-1:0] nxt_latch = frst ? '0 : ((latch_ff & ~clr_mask) | ev_line);

  // Record count survives clears and factory reset; a new scan restarts it
  wire             rec_sat = (rec_ff == '1);
  wire [REC_W-1:0] nxt_rec = new_scan ? REC_W'(ev)
                           : (rec_sat ? rec_ff : rec_ff + REC_W'(ev));

  // Query masks for the selected line and 32-channel group
  logic [31:0] routed_mask;
  logic [31:0] enabled_mask;
  always_comb begin
    routed_mask  = '0;
    enabled_mask = '0;
    for (int i = 0; i < GRP_CH; i++) begin
      routed_mask[i]  = route_ff[{qgrp_ff, GRP_SH'(i)}] == qline_ff;
      enabled_mask[i] = routed_mask[i] & en_ff[{qgrp_ff, GRP_SH'(i)}];
    end
  end

  // Read mux, sampled at the address phase so data stand in the data phase
  wire [31:0] cfg_rd  = {24'h0, pol_ff, mode_ff};
  wire [31:0] qsel_rd = {16'h0, 8'(qgrp_ff), 6'h0, qline_ff};
  wire [31:0] stat_rd = {rec_ff, 8'h0, act, alarm_ff};
  wire [31:0] nxt_rdata = !mapped                  ? 32'h0
                        : (a_off == ADDR_CFG)      ? cfg_rd
                        : (a_off == ADDR_QSEL)     ? qsel_rd
                        : (a_off == ADDR_ROUTED)   ? routed_mask
                        : (a_off == ADDR_ENABLED)  ? enabled_mask
                        : (a_off == ADDR_STATUS)   ? stat_rd
                        : 32'h0;

  // Bus phase tracking; writes to unmapped space are dropped silently
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0;
    end else begin
      wr_pend_ff <= addr_ok & hwrite_i & mapped & (hsize_i == 3'h2);
      wr_addr_ff <= a_off;
      hrdata_ff  <= (addr_ok & ~hwrite_i) ? nxt_rdata : hrdata_ff;
    end
  end

  // Per-line behaviour and polarity, indexed or all lines at once
  wire [1:0]           cfg_line = hwdata_i[CFG_LINE_LSB +: 2];
  wire [NUM_LINES-1:0] cfg_sel  = hwdata_i[CFG_ALL_BIT] ? '1 : (NUM_LINES'(1) << cfg_line);
  wire [NUM_LINES-1:0] cfg_val  = hwdata_i[CFG_VAL_BIT] ? '1 : '0;
  wire [NUM_LINES-1:0] nxt_mode = (wr_cfg & ~hwdata_i[CFG_SEL_BIT])
                                ? ((mode_ff & ~cfg_sel) | (cfg_val & cfg_sel)) : mode_ff;
  wire [NUM_LINES-1:0] nxt_pol  = (wr_cfg & hwdata_i[CFG_SEL_BIT])
                                ? ((pol_ff & ~cfg_sel) | (cfg_val & cfg_sel)) : pol_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || frst) begin
      mode_ff <= {NUM_LINES{MODE_LATCHED}};
      pol_ff  <= {NUM_LINES{POL_ACTIVE_LOW}};
    end else begin
      mode_ff <= nxt_mode;
      pol_ff  <= nxt_pol;
    end
  end

  // Routing: one 2-bit line index per channel, so a new route replaces the old
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst_i || frst) begin
        route_ff[c] <= FIRST_ALARM_LINE;
      end else if (wr_route && in_range(c, hwdata_i)) begin
        route_ff[c] <= hwdata_i[ROUTE_LINE_LSB +: 2];
      end
    end
  end

  // Checking enables and per-channel out-of-limit state
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst_i || frst) begin
        en_ff[c]  <= 1'b0;
        out_ff[c] <= 1'b0;
      end else begin
        if (wr_enable && in_range(c, hwdata_i)) begin
          en_ff[c] <= hwdata_i[EN_VAL_BIT];
        end
        if (rd_en && (rd_chan_i == CHW'(c))) begin
          out_ff[c] <= rd_out_i;
        end else if (clr_mask[route_ff[c]] || (wr_enable && in_range(c, hwdata_i))) begin
          out_ff[c] <= 1'b0;
        end
      end
    end
  end

  // Line latches, record count, query select and output pins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_ff <= '0;
      rec_ff   <= '0;
      qline_ff <= 2'h0;
      qgrp_ff  <= '0;
      alarm_ff <= '1;                              // Idle level of active-low lines
    end else begin
      latch_ff <= nxt_latch;
      rec_ff   <= nxt_rec;
      qline_ff <= wr_qsel ? hwdata_i[QSEL_LINE_LSB +: 2] : qline_ff;
      qgrp_ff  <= wr_qsel ? hwdata_i[QSEL_GRP_LSB +: GW] : qgrp_ff;
      alarm_ff <= nxt_pin;
    end
  end

  assign hrdata_o    = hrdata_ff;
  assign alarm_o     = alarm_ff;
  // Bus answer flops; the slave never stretches a phase or signals an error,
  // so software may clear a line at any moment, even while a scan runs
  logic hready_ff;
  logic hresp_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hready_ff <= 1'b1;
      hresp_ff  <= HRESP_OKAY;
    end else begin
      hready_ff <= 1'b1;                           // Every access completes without wait
      hresp_ff  <= HRESP_OKAY;
    end
  end

  assign hreadyout_o = hready_ff;
  assign hresp_o     = hresp_ff;

  // Checks on the line behaviour
  latch_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ev && !frst) |=> ((latch_ff & $past(ev_line)) == $past(ev_line)))
    else $error("latched line missed an alarm");
  clear_all_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clr_all && !ev) |=> (latch_ff == '0))
    else $error("clear all left a line latched");
  new_scan_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (new_scan && !ev && !frst) |=> (rec_ff == '0) && (out_ff == '0) && (latch_ff == '0))
    else $error("new scan did not erase alarm state");
  clear_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ((clr_one || clr_all || frst) && !new_scan) |=> (rec_ff >= $past(rec_ff)))
    else $error("clear or factory reset lost alarm records");
  frst_cfg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frst |=> (mode_ff == '0) && (pol_ff == '0) && (en_ff == '0) && (latch_ff == '0))
    else $error("factory reset left settings");
  frst_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frst |=> (route_ff[0] == FIRST_ALARM_LINE) && (route_ff[NUM_CH-1] == FIRST_ALARM_LINE))
    else $error("factory reset did not route to first line");
  track_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_en && !rd_out_i && !frst) |=> !out_ff[$past(rd_chan_i)])
    else $error("in-limit reading left channel out");
  pin_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ev && !frst && !wr_cfg && (mode_ff[ev_ln] == MODE_LATCHED)) |=> ##1
      (((alarm_o ^ $past(pol_ff)) & $past(ev_line, 2)) == '0))
    else $error("alarm pin not at active level");

  // A single clear drops the addressed latch
  clear_one_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clr_one && !ev && !frst) |=> ((latch_ff & $past(NUM_LINES'(1) << cmd_line)) == '0))
    else $error("clear one left its line latched");

  // Factory reset keeps the record count when no event coincides
  frst_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (frst && !ev) |=> (rec_ff == $past(rec_ff)))
    else $error("factory reset changed the record count");

  // Factory reset brings every pin to the idle level of an active-low line
  frst_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frst |=> ##1 (alarm_o == '1))
    else $error("factory reset left a pin active");

  // Factory reset wins over a reading in the same cycle
  frst_win_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frst |=> (out_ff == '0))
    else $error("factory reset kept out-of-limit state");

  // Enables change only by an enable write or a factory reset
  en_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!wr_enable && !frst) |=> (en_ff == $past(en_ff)))
    else $error("checking enable changed without a write");

  // Enable write reaches the lowest channel when it lies in the range
  en_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_enable && !frst && in_range(0, hwdata_i)) |=> (en_ff[0] == $past(hwdata_i[EN_VAL_BIT])))
    else $error("enable write missed a channel");

  // A new route replaces the old line of the channel
  route_move_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_route && !frst && in_range(0, hwdata_i))
      |=> (route_ff[0] == $past(hwdata_i[ROUTE_LINE_LSB +: 2])))
    else $error("route write did not replace the line");

  // Unindexed behaviour write sets all four lines
  mode_all_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_cfg && !frst && !hwdata_i[CFG_SEL_BIT] && hwdata_i[CFG_ALL_BIT])
      |=> (mode_ff == {NUM_LINES{$past(hwdata_i[CFG_VAL_BIT])}}))
    else $error("behaviour write missed a line");

  // Indexed behaviour write sets the addressed line
  mode_one_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_cfg && !frst && !hwdata_i[CFG_SEL_BIT] && !hwdata_i[CFG_ALL_BIT])
      |=> (mode_ff[$past(cfg_line)] == $past(hwdata_i[CFG_VAL_BIT])))
    else $error("behaviour write missed its line");

  // Unindexed polarity write sets all four lines at once
  pol_all_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_cfg && !frst && hwdata_i[CFG_SEL_BIT] && hwdata_i[CFG_ALL_BIT])
      |=> (pol_ff == {NUM_LINES{$past(hwdata_i[CFG_VAL_BIT])}}))
    else $error("polarity write missed a line");

  // Indexed polarity write sets the addressed line
  pol_one_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_cfg && !frst && hwdata_i[CFG_SEL_BIT] && !hwdata_i[CFG_ALL_BIT])
      |=> (pol_ff[$past(cfg_line)] == $past(hwdata_i[CFG_VAL_BIT])))
    else $error("polarity write missed its line");

  // An out-of-limit reading marks its channel
  track_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_en && rd_out_i && !frst) |=> out_ff[$past(rd_chan_i)])
    else $error("out-of-limit reading not recorded");

  // A new scan with a coincident event restarts the count at one
  scan_rec_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (new_scan && ev) |=> (rec_ff == REC_W'(1)))
    else $error("new scan lost a coincident record");

  // Query select follows the last write
  qsel_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_qsel |=> (qline_ff == $past(hwdata_i[QSEL_LINE_LSB +: 2])))
    else $error("query line select not stored");

  // Query group follows the last write
  qgrp_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_qsel |=> (qgrp_ff == $past(hwdata_i[QSEL_GRP_LSB +: GW])))
    else $error("query group select not stored");

  // The bus is always ready and always answers OKAY
  ready_okay_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hreadyout_o && (hresp_o == HRESP_OKAY))
    else $error("bus answer not ready or not OKAY");
endmodule
`default_nettype wire

// ### inc/aol_pkg.sv
// Purpose: Shared constants of the alarm output line controller
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses; field positions are bit indices
`default_nettype none
package aol_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_ROUTE   = 8'h08;
  localparam logic [7:0] ADDR_ENABLE  = 8'h0C;
  localparam logic [7:0] ADDR_QSEL    = 8'h10;
  localparam logic [7:0] ADDR_ROUTED  = 8'h14;
  localparam logic [7:0] ADDR_ENABLED = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1C;
  localparam int         MAP_TOP_LSB  = 5;     // Address bits above the map must be zero
  // Command register fields (write pulses)
  localparam int CMD_CLR_ONE_BIT  = 0;
  localparam int CMD_CLR_ALL_BIT  = 1;
  localparam int CMD_NEW_SCAN_BIT = 2;
  localparam int CMD_FRST_BIT     = 3;
  localparam int CMD_LINE_LSB     = 4;
  // Configuration write fields
  localparam int CFG_VAL_BIT  = 0;
  localparam int CFG_LINE_LSB = 4;
  localparam int CFG_ALL_BIT  = 6;
  localparam int CFG_SEL_BIT  = 7;             // 0 = behaviour, 1 = polarity
  localparam int CFG_POL_LSB  = 4;             // Read-back position of polarity bits
  // Channel range fields for routing and enable writes
  localparam int RANGE_LO_LSB   = 0;
  localparam int RANGE_HI_LSB   = 8;
  localparam int RANGE_W        = 8;
  localparam int ROUTE_LINE_LSB = 16;
  localparam int EN_VAL_BIT     = 16;
  // Query select fields
  localparam int QSEL_LINE_LSB = 0;
  localparam int QSEL_GRP_LSB  = 8;
  localparam int GRP_CH        = 32;           // Channels per query mask word
  localparam int GRP_SH        = 5;
  // Status read fields
  localparam int STAT_ACT_LSB = 4;
  localparam int STAT_REC_LSB = 16;
  localparam int REC_W        = 16;
  // Line settings
  localparam int         NUM_LINES       = 4;
  localparam logic       MODE_LATCHED    = 1'b0;
  localparam logic       MODE_TRACKING   = 1'b1;
  localparam logic       POL_ACTIVE_LOW  = 1'b0;
  localparam logic       POL_ACTIVE_HIGH = 1'b1;
  localparam logic [1:0] FIRST_ALARM_LINE = 2'h0;
  localparam logic       HRESP_OKAY      = 1'b0;
endpackage
`default_nettype wire

// ### bench/aol_pin_watch.sv
// Purpose: Model of the far-side equipment that watches the four alarm pins
// Assumes: Pins are plain push-pull levels sampled on the system clock
// Notes:   Counts every cycle in which any pin changes level so the bench can see spurious toggles
`timescale 1ns/1ps
`default_nettype none
module aol_pin_watch (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] alarm_i,
  output logic [15:0]     toggles_o
);
  logic [3:0] last_ff;

  // Count pin changes; a glitch-free design changes only on real events
  always_ff @(posedge core_clk_i) begin
    last_ff <= alarm_i;
    if (rst_i) begin
      toggles_o <= 16'h0;
    end else if (alarm_i !== last_ff) begin
      toggles_o <= toggles_o + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ### bench/test_alarm_output_lines.sv
// Purpose: Self-checking bench for the alarm output line controller
// Assumes: Zero-wait slave, pins settle two edges after their cause
// Notes:   Bus tasks wait on hready; the watchdog cuts any hang short
`timescale 1ns/1ps
`default_nettype none
module test_alarm_output_lines;
  import aol_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hresp, rd_valid, rd_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  rd_chan;
  logic [3:0]  alarm;
  logic [15:0] toggles;
  int          fails, total_checks;

  aol_alarm_lines #(.NUM_CH(64)) DUT (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .rd_valid_i(rd_valid), .rd_chan_i(rd_chan), .rd_out_i(rd_out),
    .alarm_o(alarm));
  aol_pin_watch u_watch (.core_clk_i(clk), .rst_i(rst), .alarm_i(alarm), .toggles_o(toggles));

  // Clock and time-zero values
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single transfer; holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    check({31'h0, hready}, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  // One reading from the limit logic, then let the pins settle
  task automatic rd(input logic [5:0] ch, input logic out);
    @(posedge clk);
    rd_valid <= 1'b1; rd_chan <= ch; rd_out <= out;
    @(posedge clk);
    rd_valid <= 1'b0; rd_out <= ~out;
    repeat (3) @(posedge clk);
  endtask

  task automatic pins(input logic [3:0] e);
    repeat (2) @(posedge clk);
    #1;
    check({28'h0, alarm}, {28'h0, e});
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog: the whole sequence needs far fewer than 50000 cycles
  initial begin
    #1ms;
    fails++;
    complete_run();
  end

  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; rd_valid = 1'b0; rd_chan = 6'h0; rd_out = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    pins(4'hF);
    rchk(ADDR_CFG, 32'h0);
    rchk(ADDR_STATUS, 32'h0000_000F);
    rchk(8'h20, 32'h0);
    $display("test reset done");
    // Latched line, routed channel, then in-limit reading keeps it
    wr(ADDR_ENABLE, 32'h0001_0700);
    wr(ADDR_ROUTE, 32'h0001_0202);
    rd(6'd2, 1'b1); pins(4'hD);
    rd(6'd2, 1'b0); pins(4'hD);
    rchk(ADDR_STATUS, 32'h0001_002D);
    wr(ADDR_CMD, 32'h0000_0011); pins(4'hF);
    rchk(ADDR_STATUS, 32'h0001_000F);
    rd(6'd2, 1'b1); rd(6'd5, 1'b1); pins(4'hC);
    wr(ADDR_CMD, 32'h0000_0002); pins(4'hF);
    rchk(ADDR_STATUS, 32'h0003_000F);
    check({16'h0, toggles}, 32'h5);
    $display("test latched done");
    // Tracking on all lines, then polarity for all and for one line
    wr(ADDR_CFG, 32'h0000_0041);
    rchk(ADDR_CFG, 32'h0000_000F);
    rd(6'd2, 1'b1); pins(4'hD);
    rd(6'd2, 1'b0); pins(4'hF);
    wr(ADDR_CFG, 32'h0000_00C1); pins(4'h0);
    rchk(ADDR_CFG, 32'h0000_00FF);
    rd(6'd2, 1'b1); pins(4'h2);
    wr(ADDR_CFG, 32'h0000_00B0); pins(4'hA);
    rchk(ADDR_CFG, 32'h0000_007F);
    $display("test modes done");
    // New scan drops the lines and the records
    wr(ADDR_CMD, 32'h0000_0004); pins(4'h8);
    rchk(ADDR_STATUS, 32'h0000_0008);
    rd(6'd2, 1'b1); pins(4'hA);
    $display("test scan done");
    // Routing and enable queries; rerouting replaces the old line
    wr(ADDR_QSEL, 32'h1);
    rchk(ADDR_ROUTED, 32'h0000_0004);
    rchk(ADDR_ENABLED, 32'h0000_0004);
    wr(ADDR_ROUTE, 32'h0002_0202); pins(4'hC);
    rchk(ADDR_ROUTED, 32'h0);
    wr(ADDR_QSEL, 32'h0);
    rchk(ADDR_ROUTED, 32'hFFFF_FFFB);
    rchk(ADDR_ENABLED, 32'h0000_00FB);
    $display("test routing done");
    // Factory reset restores defaults and keeps the record count
    wr(ADDR_CMD, 32'h0000_0008); pins(4'hF);
    rchk(ADDR_CFG, 32'h0);
    rchk(ADDR_STATUS, 32'h0001_000F);
    rchk(ADDR_ROUTED, 32'hFFFF_FFFF);
    rchk(ADDR_ENABLED, 32'h0);
    rd(6'd2, 1'b1); pins(4'hF);
    $display("test factory done");
    complete_run();
  end
endmodule
`default_nettype wire
